// >>> pgd_pkg.sv
// Shared constants and types for the planar graphics data path.
// Assumes a single 50 MHz clock domain; no timing counts are needed.
`default_nettype none

package pgd_pkg;

  // ==========================================================================
  // Register indices behind the index/data port pair
  localparam logic [3:0] IDX_SET_RESET_VALUE   = 4'h0;
  localparam logic [3:0] IDX_SET_RESET_ENABLE  = 4'h1;
  localparam logic [3:0] IDX_COLOR_COMPARE     = 4'h2;
  localparam logic [3:0] IDX_ROTATE_AND_FUNC   = 4'h3;
  localparam logic [3:0] IDX_READ_PLANE_SELECT = 4'h4;
  localparam logic [3:0] IDX_GRAPHICS_MODE_CTL = 4'h5;
  localparam logic [3:0] IDX_MISC_GRAPHICS_CTL = 4'h6;
  localparam logic [3:0] IDX_COLOR_IGNORE_MASK = 4'h7;
  localparam logic [3:0] IDX_PIXEL_WRITE_MASK  = 4'h8;
  localparam int         NUM_REGS              = 9;

  // ==========================================================================
  // Implemented bits of each register; reserved bits read as zero
  localparam logic [7:0] MASK_NIBBLE     = 8'h0f;
  localparam logic [7:0] MASK_ROTATE_FN  = 8'h1f;
  localparam logic [7:0] MASK_PLANE_SEL  = 8'h03;
  localparam logic [7:0] MASK_MODE       = 8'h7b;
  localparam logic [7:0] MASK_FULL       = 8'hff;
  localparam logic [7:0] REG_RESET       = 8'h00;
  localparam logic [3:0] INDEX_RESET     = 4'h0;

  // ==========================================================================
  // Field positions
  localparam int ROT_LSB    = 0;
  localparam int FUNC_LSB   = 3;
  localparam int WMODE_LSB  = 0;
  localparam int RMODE_BIT  = 3;
  localparam int ODDEV_BIT  = 4;
  localparam int SHIFT_LSB  = 5;

  // ==========================================================================
  // Modes
  typedef enum logic [1:0] {FN_PASS, FN_AND, FN_OR, FN_XOR} pgd_func_t;
  typedef enum logic [1:0] {WM_0, WM_1, WM_2, WM_3} pgd_wmode_t;

  localparam logic [3:0] PLANES_EVEN = 4'h5;
  localparam logic [3:0] PLANES_ODD  = 4'ha;
  localparam logic [3:0] PLANES_ALL  = 4'hf;

endpackage : pgd_pkg

`default_nettype wire

// >>> pgd_shifter.sv
// Video serialiser: four plane bytes into pixel bits per shift pattern.
// Assumes load and shift strobes come from the sequencer in the same clock.
`timescale 1ns/1ns
`default_nettype none

module pgd_shifter
  import pgd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       load,
  input  wire logic       shift,
  input  wire logic       chain,
  input  wire logic       video8,
  input  wire logic [1:0] pattern,
  input  wire logic [7:0] plane0,
  input  wire logic [7:0] plane1,
  input  wire logic [7:0] plane2,
  input  wire logic [7:0] plane3,
  output logic      [7:0] pixel
);

  logic [3:0][7:0] p;
  logic [3:0][7:0] fill_d;
  logic [31:0]     sr_q;
  logic [3:0]      chain_in;

  assign p = {plane3, plane2, plane1, plane0};
  // Top lane has no upper neighbour and fills zero
  assign chain_in = chain ? {1'b0, sr_q[31], sr_q[23], sr_q[15]} : 4'h0;

  // ==========================================================================
  // Load patterns; bit 7 of each lane leaves first
  always_comb begin
    fill_d = '0;
    for (int n = 0; n < 4; n++) begin
      if (pattern == 2'b00) begin
        fill_d[n] = p[n];
      end else if (pattern == 2'b01) begin
        for (int j = 0; j < 4; j++) begin
          fill_d[n][7-j] = p[n & 2][6-2*j+(n & 1)];
          fill_d[n][3-j] = p[(n & 2)+1][6-2*j+(n & 1)];
        end
      end else begin
        for (int q = 0; q < 4; q++) begin
          fill_d[n][7-2*q] = p[q][4+n];
          fill_d[n][6-2*q] = p[q][n];
        end
      end
    end
  end

  // ==========================================================================
  // Shift registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_q <= '0;
    end else if (load) begin
      if (video8) begin
        for (int k = 0; k < 8; k++) begin
          for (int q = 0; q < 4; q++) begin
            sr_q[4*k+3-q] <= p[q][k];
          end
        end
      end else begin
        sr_q <= fill_d;
      end
    end else if (shift) begin
      if (video8) begin
        for (int k = 0; k < 8; k++) begin
          sr_q[4*k +: 4] <= {sr_q[4*k +: 3], 1'b0};
        end
      end else begin
        for (int n = 0; n < 4; n++) begin
          // Without a reload the lanes chain downward, top lane fills zero
          sr_q[8*n +: 8] <= {sr_q[8*n +: 7], chain_in[n]};
        end
      end
    end
  end

  always_comb begin
    pixel = '0;
    for (int k = 0; k < 8; k++) begin
      if (video8) begin
        pixel[k] = sr_q[4*k+3];
      end else if (k < 4) begin
        pixel[k] = sr_q[8*k+7];
      end
    end
  end

endmodule // pgd_shifter

`default_nettype wire

// >>> pgd_datapath.sv
// Planar graphics data path: index/data register port, CPU write
// processing, CPU read selection/compare, and the video serialiser.
// Assumes plane read data is valid in the cycle of the CPU read strobe.
// Register writes take effect for the next cycle's processing.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Mode 0: enabled planes take set/reset value
// - Set/reset enables only act in mode 0
// - Rotate CPU write data right by count
// - Function: pass, AND, OR, XOR with latches
// - Every CPU read loads the four latches
// - Mode 1 writes latch contents to planes
// - Mode 2: low nibble colour, masked, function
// - Mode 3: rotated data AND mask selects colour
// - Wide writes processed per byte lane
// - Read mode 0 returns selected plane
// - Odd/even ignores bit 0; quad ignores both
// - Read mode 1 returns per-pixel colour match
// - Mode bit 3 selects read mode
// - Compare done separately per byte lane
// - Odd/even splits planes by address bit 0
// - Pattern 00: plane n to output n
// - Pattern 01: 2-bit pixels, plane pairs
// - Pattern 1x: 4-bit pixels, nibbles per plane
// - No reload: 4-bit path shift registers chain downward
// - 8-bit path: 8-bit pixels, plane 0 first
// - Ignore bit 0 drops plane from compare
// - Write mask 0 keeps latch bit
module pgd_datapath
  import pgd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Index/data register port
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic        io_data_sel,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  // Sequencer and extension levels
  input  wire logic        seq_quad_mode,
  input  wire logic        seq_no_reload,
  input  wire logic        ext_video8_en,
  // CPU display memory access
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  input  wire logic [1:0]  cpu_addr,
  input  wire logic [3:0]  cpu_be,
  input  wire logic [31:0] cpu_wdata,
  output logic      [31:0] cpu_rdata,
  output logic             cpu_rvalid,
  // Plane read data for the CPU access
  input  wire logic [31:0] mem_rdata0,
  input  wire logic [31:0] mem_rdata1,
  input  wire logic [31:0] mem_rdata2,
  input  wire logic [31:0] mem_rdata3,
  // Plane write data
  output logic             mem_wr,
  output logic      [3:0]  mem_be,
  output logic      [3:0]  mem_plane_en,
  output logic      [31:0] mem_wdata0,
  output logic      [31:0] mem_wdata1,
  output logic      [31:0] mem_wdata2,
  output logic      [31:0] mem_wdata3,
  // Video side
  input  wire logic        vid_load,
  input  wire logic        vid_shift,
  input  wire logic [7:0]  vid_plane0,
  input  wire logic [7:0]  vid_plane1,
  input  wire logic [7:0]  vid_plane2,
  input  wire logic [7:0]  vid_plane3,
  output logic      [7:0]  vid_pixel
);

  // ==========================================================================
  // Register file
  logic [3:0]           index_q;
  logic [7:0]           regs_q [NUM_REGS];
  logic [3:0][7:0]      latch_q;
  logic [3:0][31:0]     rd_planes;
  logic [3:0][31:0]     wr_planes_d;
  logic [31:0]          rdata_d;
  logic [3:0]           plane_en_d;
  logic [1:0]           rd_plane;

  logic [3:0]  sr_value;
  logic [3:0]  sr_enable;
  logic [3:0]  cmp_color;
  logic [3:0]  cmp_care;
  logic [2:0]  rot_count;
  pgd_func_t   func_sel;
  pgd_wmode_t  wmode;
  logic        rmode;
  logic        odd_even;
  logic [1:0]  shift_pat;
  logic [7:0]  bit_mask;

  // ==========================================================================
  // Register fields; reserved bits are already zero in the file
  assign sr_value  = regs_q[IDX_SET_RESET_VALUE][3:0];
  assign sr_enable = regs_q[IDX_SET_RESET_ENABLE][3:0];
  assign cmp_color = regs_q[IDX_COLOR_COMPARE][3:0];
  assign cmp_care  = regs_q[IDX_COLOR_IGNORE_MASK][3:0];
  assign rot_count = regs_q[IDX_ROTATE_AND_FUNC][ROT_LSB +: 3];
  assign func_sel  = pgd_func_t'(regs_q[IDX_ROTATE_AND_FUNC][FUNC_LSB +: 2]);
  assign wmode     = pgd_wmode_t'(regs_q[IDX_GRAPHICS_MODE_CTL][WMODE_LSB +: 2]);
  assign rmode     = regs_q[IDX_GRAPHICS_MODE_CTL][RMODE_BIT];
  assign odd_even  = regs_q[IDX_GRAPHICS_MODE_CTL][ODDEV_BIT];
  assign shift_pat = regs_q[IDX_GRAPHICS_MODE_CTL][SHIFT_LSB +: 2];
  assign bit_mask  = regs_q[IDX_PIXEL_WRITE_MASK];

  assign rd_planes = {mem_rdata3, mem_rdata2, mem_rdata1, mem_rdata0};

  // ==========================================================================
  // Index/data register port
  // Reserved bits drop on the way in, so reads need no masking
  function automatic logic [7:0] reg_mask(input logic [3:0] idx);
    unique case (idx)
      IDX_ROTATE_AND_FUNC:   reg_mask = MASK_ROTATE_FN;
      IDX_READ_PLANE_SELECT: reg_mask = MASK_PLANE_SEL;
      IDX_GRAPHICS_MODE_CTL: reg_mask = MASK_MODE;
      IDX_PIXEL_WRITE_MASK:  reg_mask = MASK_FULL;
      default:               reg_mask = MASK_NIBBLE;
    endcase
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      index_q <= INDEX_RESET;
    end else if (io_wr && !io_data_sel) begin
      index_q <= io_wdata[3:0];
    end
  end

  // Writes to indices past the last register are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= REG_RESET;
      end
    end else if (io_wr && io_data_sel && index_q < 4'(NUM_REGS)) begin
      regs_q[index_q] <= io_wdata & reg_mask(index_q);
    end
  end

  // Index reads back so software can save and restore it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata <= '0;
    end else if (io_rd) begin
      if (!io_data_sel) begin
        io_rdata <= {4'h0, index_q};
      end else if (index_q < 4'(NUM_REGS)) begin
        io_rdata <= regs_q[index_q];
      end else begin
        io_rdata <= '0;
      end
    end
  end

  // ==========================================================================
  // Write processing, one byte lane
  // Applied after substitution, before the mask
  function automatic logic [7:0] alu(input logic [7:0] d, input logic [7:0] l);
    unique case (func_sel)
      FN_PASS: alu = d;
      FN_AND:  alu = d & l;
      FN_OR:   alu = d | l;
      FN_XOR:  alu = d ^ l;
    endcase
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] d, input logic [7:0] l,
                                       input logic [7:0] m);
    merge = (d & m) | (l & ~m);
  endfunction

  // One CPU byte gives all four plane bytes in one pass
  function automatic logic [3:0][7:0] write_lane(input logic [7:0] d);
    logic [7:0]      rot;
    logic [7:0]      src;
    logic [7:0]      m3;
    rot = (d >> rot_count) | 8'(d << (4'h8 - {1'b0, rot_count}));
    m3  = rot & bit_mask;
    src = '0;
    write_lane = '0;
    for (int p = 0; p < 4; p++) begin
      unique case (wmode)
        WM_0: begin
          src = sr_enable[p] ? {8{sr_value[p]}} : rot;
          write_lane[p] = merge(alu(src, latch_q[p]), latch_q[p], bit_mask);
        end
        // Mask is moot: a masked bit keeps the latch anyway
        WM_1: write_lane[p] = latch_q[p];
        WM_2: begin
          src = {8{d[p]}};
          write_lane[p] = merge(alu(src, latch_q[p]), latch_q[p], bit_mask);
        end
        // No logical function; the colour goes in as it stands
        WM_3: write_lane[p] = merge({8{sr_value[p]}}, latch_q[p], m3);
      endcase
    end
  endfunction

  // Every lane sees the same latches; only the CPU byte differs
  always_comb begin
    wr_planes_d = '0;
    for (int b = 0; b < 4; b++) begin
      logic [3:0][7:0] lane;
      lane = write_lane(cpu_wdata[8*b +: 8]);
      for (int p = 0; p < 4; p++) begin
        wr_planes_d[p][8*b +: 8] = lane[p];
      end
    end
  end

  // ==========================================================================
  // Plane selection by addressing mode
  // Quad addressing wins over odd/even; both split on the address bits
  always_comb begin
    if (seq_quad_mode) begin
      plane_en_d = 4'(4'h1 << cpu_addr);
    end else if (odd_even) begin
      plane_en_d = cpu_addr[0] ? PLANES_ODD : PLANES_EVEN;
    end else begin
      plane_en_d = PLANES_ALL;
    end
  end

  // Quad mode takes the plane from the address; odd/even takes bit 0 from the address, bit 1 from the select field
  always_comb begin
    if (seq_quad_mode) begin
      rd_plane = cpu_addr;
    end else if (odd_even) begin
      rd_plane = {regs_q[IDX_READ_PLANE_SELECT][1], cpu_addr[0]};
    end else begin
      rd_plane = regs_q[IDX_READ_PLANE_SELECT][1:0];
    end
  end

  // ==========================================================================
  // Plane write port
  // Enables and data hold after the pulse for a late sampling plane side
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_wr       <= 1'b0;
      mem_be       <= '0;
      mem_plane_en <= '0;
      mem_wdata0   <= '0;
      mem_wdata1   <= '0;
      mem_wdata2   <= '0;
      mem_wdata3   <= '0;
    end else begin
      mem_wr <= cpu_wr;
      if (cpu_wr) begin
        mem_be       <= cpu_be;
        mem_plane_en <= plane_en_d;
        mem_wdata0   <= wr_planes_d[0];
        mem_wdata1   <= wr_planes_d[1];
        mem_wdata2   <= wr_planes_d[2];
        mem_wdata3   <= wr_planes_d[3];
      end
    end
  end

  // ==========================================================================
  // Read path
  // Lowest enabled lane; no enables falls back to lane 0
  function automatic logic [1:0] low_lane(input logic [3:0] be);
    low_lane = be[0] ? 2'd0 : be[1] ? 2'd1 : be[2] ? 2'd2 : be[3] ? 2'd3 : 2'd0;
  endfunction

  // A cleared care bit drops that plane from the match
  function automatic logic [7:0] compare_lane(input logic [1:0] b);
    logic [3:0] pix;
    pix = '0;
    compare_lane = '0;
    for (int k = 0; k < 8; k++) begin
      for (int p = 0; p < 4; p++) begin
        pix[p] = rd_planes[p][8*b+k];
      end
      compare_lane[k] = ~|((pix ^ cmp_color) & cmp_care);
    end
  endfunction

  // Both read modes work per lane, so wide reads need no sequencing
  always_comb begin
    rdata_d = '0;
    for (int b = 0; b < 4; b++) begin
      if (rmode) begin
        rdata_d[8*b +: 8] = compare_lane(2'(b));
      end else begin
        rdata_d[8*b +: 8] = rd_planes[rd_plane][8*b +: 8];
      end
    end
  end

  // Latches hold one byte per plane; a wide read keeps its lowest lane
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= '0;
    end else if (cpu_rd) begin
      for (int p = 0; p < 4; p++) begin
        latch_q[p] <= rd_planes[p][8*low_lane(cpu_be) +: 8];
      end
    end
  end

  // Registered so the host takes a settled word after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_rdata  <= '0;
      cpu_rvalid <= 1'b0;
    end else begin
      cpu_rvalid <= cpu_rd;
      if (cpu_rd) begin
        cpu_rdata <= rdata_d;
      end
    end
  end

  // ==========================================================================
  // Video serialiser
  // Chain from the sequencer and 8-bit path from the extension are plain levels
  pgd_shifter u_shifter (
    .clk     (clk),
    .rst_n   (rst_n),
    .load    (vid_load),
    .shift   (vid_shift),
    .chain   (seq_no_reload),
    .video8  (ext_video8_en),
    .pattern (shift_pat),
    .plane0  (vid_plane0),
    .plane1  (vid_plane1),
    .plane2  (vid_plane2),
    .plane3  (vid_plane3),
    .pixel   (vid_pixel)
  );

endmodule // pgd_datapath

`default_nettype wire

// >>> pgd_datapath_asserts.sv
// Port-level checks for the planar graphics data path.
// Assumes the one clk domain and rst_n asynchronous, active low.
`timescale 1ns/1ns
`default_nettype none

module pgd_datapath_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        io_rd,
  input wire logic [7:0]  io_rdata,
  input wire logic        ext_video8_en,
  input wire logic        cpu_wr,
  input wire logic        cpu_rd,
  input wire logic [3:0]  cpu_be,
  input wire logic [31:0] cpu_rdata,
  input wire logic        cpu_rvalid,
  input wire logic        mem_wr,
  input wire logic [3:0]  mem_be,
  input wire logic        vid_load,
  input wire logic        vid_shift,
  input wire logic [7:0]  vid_pixel
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ==========
  // Sequences
  sequence s_narrow_load;
    vid_load && !ext_video8_en;
  endsequence
  // Path select alone changes the pixel view without a shift
  sequence s_pix_idle;
    (!vid_load && !vid_shift) ##1 $stable(ext_video8_en);
  endsequence

  // ==========
  // Properties
  property p_wr_ack;
    cpu_wr |=> mem_wr && mem_be == $past(cpu_be);
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("plane write missing after cpu write");
  // Stray writes would clobber planes the mask protects
  property p_wr_only;
    !cpu_wr |=> !mem_wr;
  endproperty
  a_wr_only: assert property (p_wr_only)
    else $error("plane write without cpu write");
  property p_rd_ack;
    cpu_rd |=> cpu_rvalid;
  endproperty
  a_rd_ack: assert property (p_rd_ack)
    else $error("read not answered");
  property p_rd_only;
    !cpu_rd |=> !cpu_rvalid;
  endproperty
  a_rd_only: assert property (p_rd_only)
    else $error("read valid without read");
  property p_rd_hold;
    !cpu_rd |=> $stable(cpu_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without read");
  property p_io_hold;
    !io_rd |=> $stable(io_rdata);
  endproperty
  a_io_hold: assert property (p_io_hold)
    else $error("register data moved without read");
  property p_narrow;
    s_narrow_load |=> vid_pixel[7:4] == 4'h0;
  endproperty
  a_narrow: assert property (p_narrow)
    else $error("upper pixel bits set in 4-bit path");
  property p_pix_hold;
    s_pix_idle |-> $stable(vid_pixel);
  endproperty
  a_pix_hold: assert property (p_pix_hold)
    else $error("pixel moved without load or shift");
endmodule // pgd_datapath_chk

bind pgd_datapath pgd_datapath_chk u_chk (
  .clk(clk), .rst_n(rst_n), .io_rd(io_rd), .io_rdata(io_rdata),
  .ext_video8_en(ext_video8_en), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
  .cpu_be(cpu_be), .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
  .mem_wr(mem_wr), .mem_be(mem_be), .vid_load(vid_load),
  .vid_shift(vid_shift), .vid_pixel(vid_pixel)
);
`default_nettype wire

// >>> pgd_mem_model.sv
// Display memory: one 32-bit word per plane.
// Assumes the testbench may preload pl directly between accesses.
`timescale 1ns/1ns
`default_nettype none

module pgd_mem_model (
  input  wire logic        clk,
  input  wire logic        mem_wr,
  input  wire logic [3:0]  mem_be,
  input  wire logic [3:0]  mem_plane_en,
  input  wire logic [31:0] mem_wdata [4],
  output logic      [31:0] mem_rdata [4]
);
  logic [31:0] pl [4];

  assign mem_rdata = pl;

  // Only enabled planes and lanes change
  always @(posedge clk) begin
    if (mem_wr) begin
      for (int p = 0; p < 4; p++) begin
        for (int b = 0; b < 4; b++) begin
          if (mem_plane_en[p] && mem_be[b]) begin
            pl[p][8*b +: 8] <= mem_wdata[p][8*b +: 8];
          end
        end
      end
    end
  end
endmodule // pgd_mem_model
`default_nettype wire

// >>> tb_planar_graphics_datapath.sv
// Self-checking bench for the planar graphics data path.
// Assumes pgd_mem_model stands in for the display planes.
`timescale 1ns/1ns
`default_nettype none

module tb_planar_graphics_datapath;
  logic        clk, rst_n, io_wr, io_rd, io_data_sel;
  logic        seq_quad_mode, seq_no_reload, ext_video8_en;
  logic        cpu_wr, cpu_rd, cpu_rvalid, mem_wr, vid_load, vid_shift;
  logic [1:0]  cpu_addr;
  logic [3:0]  cpu_be, mem_be, mem_plane_en;
  logic [7:0]  io_wdata, io_rdata, vid_pixel;
  logic [7:0]  vp [4];
  logic [31:0] cpu_wdata, cpu_rdata;
  logic [31:0] rd [4];
  logic [31:0] wd [4];
  logic [31:0] pv [4];
  int          num_errors, comparisons;

  pgd_datapath uut (
    .clk(clk), .rst_n(rst_n), .io_wr(io_wr), .io_rd(io_rd),
    .io_data_sel(io_data_sel), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .seq_quad_mode(seq_quad_mode), .seq_no_reload(seq_no_reload),
    .ext_video8_en(ext_video8_en), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_addr(cpu_addr), .cpu_be(cpu_be), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid),
    .mem_rdata0(rd[0]), .mem_rdata1(rd[1]), .mem_rdata2(rd[2]),
    .mem_rdata3(rd[3]), .mem_wr(mem_wr), .mem_be(mem_be),
    .mem_plane_en(mem_plane_en), .mem_wdata0(wd[0]), .mem_wdata1(wd[1]),
    .mem_wdata2(wd[2]), .mem_wdata3(wd[3]), .vid_load(vid_load),
    .vid_shift(vid_shift), .vid_plane0(vp[0]), .vid_plane1(vp[1]),
    .vid_plane2(vp[2]), .vid_plane3(vp[3]), .vid_pixel(vid_pixel)
  );
  pgd_mem_model mem (
    .clk(clk), .mem_wr(mem_wr), .mem_be(mem_be),
    .mem_plane_en(mem_plane_en), .mem_wdata(wd), .mem_rdata(rd)
  );

  // ==========
  // Helpers
  task automatic chk(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Leaves io_wr high so the caller picks the next phase
  task automatic idx(input logic [3:0] i);
    @(negedge clk);
    io_wr = 1'b1;
    io_data_sel = 1'b0;
    io_wdata = {4'h0, i};
    @(negedge clk);
  endtask
  task automatic rw(input logic [3:0] i, input logic [7:0] v);
    idx(i);
    io_data_sel = 1'b1;
    io_wdata = v;
    @(negedge clk);
    io_wr = 1'b0;
  endtask
  task automatic rr(input logic [3:0] i, output logic [7:0] v);
    idx(i);
    io_wr = 1'b0;
    io_rd = 1'b1;
    io_data_sel = 1'b1;
    @(negedge clk);
    io_rd = 1'b0;
    v = io_rdata;
  endtask
  task automatic cw(input logic [1:0] a, input logic [31:0] d);
    @(negedge clk);
    cpu_wr = 1'b1;
    cpu_addr = a;
    cpu_wdata = d;
    @(negedge clk);
    cpu_wr = 1'b0;
    chk({31'h0, mem_wr}, 32'h1);
  endtask
  task automatic cr(input logic [1:0] a);
    @(negedge clk);
    cpu_rd = 1'b1;
    cpu_addr = a;
    @(negedge clk);
    cpu_rd = 1'b0;
    chk({31'h0, cpu_rvalid}, 32'h1);
  endtask
  task automatic lp;
    for (int p = 0; p < 4; p++) mem.pl[p] = pv[p];
  endtask
  function automatic logic [7:0] wexp(input logic [1:0] wm, fn, input logic [2:0] rot,
                                      input logic [3:0] srv, sre, input logic [7:0] bm, d, la,
                                      input int p);
    logic [15:0] t;
    logic [7:0]  v, m;
    t = {d, d} >> rot;
    m = bm;
    case (wm)
      2'h0: v = sre[p] ? {8{srv[p]}} : t[7:0];
      2'h1: v = la;
      2'h2: v = {8{d[p]}};
      default: begin
        v = {8{srv[p]}};
        m = t[7:0] & bm;
      end
    endcase
    if (!wm[0]) v = fn == 2'h1 ? v & la : fn == 2'h2 ? v | la : fn == 2'h3 ? v ^ la : v;
    return (v & m) | (la & ~m);
  endfunction
  function automatic logic [7:0] pix(input logic [1:0] pat, input logic v8, ch, input int s);
    logic [7:0] e;
    for (int n = 0; n < 8; n++) begin
      if (v8) e[n] = vp[s][n];
      else if (n > 3) e[n] = 1'b0;
      else if (ch && s > 7) e[n] = n < 3 ? vp[n+1][15-s] : 1'b0;
      else if (!pat[1]) e[n] = pat[0] ? vp[2*(n/2)+s/4][6-2*(s%4)+n%2] : vp[n][7-s];
      else e[n] = vp[s/2][s%2 ? n : n+4];
    end
    return e;
  endfunction

  // ==========
  // Scenarios
  task automatic t_regs;
    logic [7:0] msk [9] = '{8'h0f, 8'h0f, 8'h0f, 8'h1f, 8'h03, 8'h7b, 8'h0f, 8'h0f, 8'hff};
    logic [7:0] v;
    for (int i = 0; i < 10; i++) begin
      rr(4'(i), v);
      chk(v, 0);
      rw(4'(i), 8'hff);
      rr(4'(i), v);
      chk(v, i < 9 ? msk[i] : 8'h0);
    end
  endtask
  task automatic t_rd_plane;
    rw(5, 8'h00);
    for (int p = 0; p < 4; p++) begin
      rw(4, 8'(p));
      cr(0);
      chk(cpu_rdata, pv[p]);
    end
  endtask
  task automatic t_wmodes;
    logic [31:0] e;
    logic [31:0] d = 32'h96c3a51e;
    logic [2:0]  r;
    rw(0, 8'h06);
    rw(1, 8'h09);
    rw(8, 8'h3c);
    for (int k = 0; k < 16; k++) begin
      r = 3'(k + 5);
      rw(3, {3'h0, k[1:0], r});
      rw(5, {6'h0, k[3:2]});
      cw(0, d);
      chk(mem_plane_en, 4'hf);
      for (int p = 0; p < 4; p++) begin
        for (int b = 0; b < 4; b++) e[8*b +: 8] = wexp(k[3:2], k[1:0], r, 4'h6, 4'h9, 8'h3c, d[8*b +: 8], pv[p][7:0], p);
        chk(wd[p], e);
      end
    end
  endtask
  task automatic t_addr;
    rw(4, 8'h03);
    rw(5, 8'h10);
    cr(0);
    chk(cpu_rdata, pv[2]);
    seq_quad_mode = 1'b1;
    cr(1);
    chk(cpu_rdata, pv[1]);
    cw(2, 32'h0);
    chk(mem_plane_en, 4'h4);
    seq_quad_mode = 1'b0;
    cw(1, 32'h0);
    chk(mem_plane_en, 4'ha);
    cw(0, 32'h0);
    chk(mem_plane_en, 4'h5);
  endtask
  task automatic t_cmp;
    logic [31:0] e;
    logic [3:0]  ig;
    rw(2, 8'h0a);
    rw(5, 8'h08);
    for (int c = 0; c < 3; c++) begin
      ig = 4'hf >> (2 * c);
      rw(7, {4'h0, ig});
      cr(0);
      for (int j = 0; j < 32; j++) e[j] = (({pv[3][j], pv[2][j], pv[1][j], pv[0][j]} ^ 4'ha) & ig) == 4'h0;
      chk(cpu_rdata, e);
    end
  endtask
  task automatic vr(input logic [1:0] pat, input logic v8, ch, input int n);
    rw(5, {1'b0, pat, 5'h0});
    ext_video8_en = v8;
    seq_no_reload = ch;
    @(negedge clk);
    vid_load = 1'b1;
    @(negedge clk);
    vid_load = 1'b0;
    vid_shift = 1'b1;
    for (int s = 0; s < n; s++) begin
      chk(vid_pixel, pix(pat, v8, ch, s));
      @(negedge clk);
    end
    vid_shift = 1'b0;
  endtask

  task automatic wrap_up;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    wrap_up;
  end
  initial begin
    {rst_n, io_wr, io_rd, io_data_sel, io_wdata} = '0;
    {seq_quad_mode, seq_no_reload, ext_video8_en} = '0;
    {cpu_wr, cpu_rd, cpu_addr, cpu_wdata, vid_load, vid_shift} = '0;
    cpu_be = 4'hf;
    num_errors = 0;
    comparisons = 0;
    vp = '{8'h9c, 8'h35, 8'he1, 8'h4b};
    pv = '{32'h18244281, 32'hf00f33cc, 32'h55aa0ff0, 32'h0000ffff};
    lp;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_regs;
    t_rd_plane;
    t_wmodes;
    // Let the last plane write land before the planes are restored
    @(negedge clk);
    lp;
    t_addr;
    @(negedge clk);
    lp;
    t_cmp;
    vr(2'h0, 1'b0, 1'b0, 8);
    vr(2'h1, 1'b0, 1'b0, 8);
    vr(2'h2, 1'b0, 1'b0, 8);
    vr(2'h3, 1'b0, 1'b0, 8);
    vr(2'h0, 1'b1, 1'b0, 4);
    vr(2'h1, 1'b1, 1'b0, 4);
    vr(2'h0, 1'b0, 1'b1, 16);
    wrap_up;
  end
endmodule // tb_planar_graphics_datapath
`default_nettype wire
